// ---- mstm_pkg.sv ----
// Constants and types for the motor status monitor.
// Assumes a 200 MHz clock and current magnitudes in a common 16-bit unit.
package mstm_pkg;
    localparam int          CUR_W          = 16;
    localparam int          CNT_W          = 32;
    localparam int          CLK_MHZ        = 200;
    localparam int          NOLOAD_MS      = 10;
    localparam int          RISE_MS        = 10;
    localparam int          TICK_US        = 1000;
    localparam int          NOLOAD_CYC     = NOLOAD_MS * 1000 * CLK_MHZ;
    localparam int          RISE_CYC       = RISE_MS * 1000 * CLK_MHZ;
    localparam int          TICK_CYC       = TICK_US * CLK_MHZ;
    localparam logic [15:0] FACTOR_ONE     = 16'h0100;
    localparam logic [3:0]  FORCE_RST      = 4'h0;
    localparam logic [1:0]  STARTMODE_RST  = 2'h0;
    localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS    = 32'h0000_0004;
    localparam logic [31:0] ADDR_NOLOAD    = 32'h0000_0008;
    localparam logic [31:0] ADDR_STARTDET  = 32'h0000_000C;
    localparam logic [31:0] ADDR_NOMINAL   = 32'h0000_0010;
    localparam logic [31:0] ADDR_MAXOVL    = 32'h0000_0014;
    localparam logic [31:0] ADDR_MAXLR     = 32'h0000_0018;
    localparam logic [31:0] ADDR_FACTORS   = 32'h0000_001C;
    localparam logic [31:0] ADDR_STARTS    = 32'h0000_0020;
    localparam logic [31:0] ADDR_GOODSTART = 32'h0000_0024;
    localparam logic [31:0] ADDR_STOPS     = 32'h0000_0028;
    localparam logic [31:0] ADDR_RUNTIME   = 32'h0000_002C;
    localparam logic [31:0] ADDR_STARTTIME = 32'h0000_0030;
    localparam logic [31:0] ADDR_STOPTIME  = 32'h0000_0034;
    localparam logic [31:0] ADDR_LASTSTOP  = 32'h0000_0038;
    localparam logic [31:0] ADDR_CLOCK     = 32'h0000_003C;
    localparam logic [15:0] NOLOAD_RST     = 16'h0020;
    localparam logic [15:0] STARTDET_RST   = 16'h0180;
    localparam logic [15:0] NOMINAL_RST    = 16'h0100;
    localparam logic [15:0] MAXOVL_RST     = 16'h0200;
    localparam logic [15:0] MAXLR_RST      = 16'h0780;
    // Force codes; no_override leaves the computed status alone
    localparam logic [3:0]  FORCE_NONE     = 4'h0;
    localparam logic [3:0]  FORCE_STOP     = 4'h1;
    localparam logic [3:0]  FORCE_START    = 4'h2;
    localparam logic [3:0]  FORCE_RUN      = 4'h3;
    localparam logic [3:0]  FORCE_STALL    = 4'h4;
    localparam logic [3:0]  FORCE_ASYM     = 4'h5;
    localparam logic [3:0]  FORCE_NORM     = 4'h6;
    localparam logic [3:0]  FORCE_OVL      = 4'h7;
    localparam logic [3:0]  FORCE_HIOVL    = 4'h8;
    localparam logic [1:0]  MODE_DIRECT    = 2'h0;
    localparam logic [1:0]  MODE_STARDELTA = 2'h1;
    localparam logic [1:0]  MODE_SOFT      = 2'h2;
    typedef enum logic [1:0] {ST_STOPPED, ST_STARTING, ST_RUNNING} mstm_state_e;
endpackage

// ---- mstm_top.sv ----
// Motor status monitor: APB settings, status outputs, counters and timers.
// Assumes phase current magnitudes synchronous to clk with a one-cycle sample strobe.
// Behaviour
// - Count every detected motor start.
// - Count starts that pass into running.
// - Count each entry into the stopped state.
// - Accumulate running time and starting time separately.
// - Accumulate stopped time and keep the last stop timestamp.
// - Stopped when current stays under no-load for over 10 ms.
// - From stopped, start when current exceeds start-detect limit.
// - Stay starting while current is at or above maximum overload.
// - Starting ends into running once current falls under maximum overload.
// - Normal load between no-load and factor-adjusted nominal current.
// - Overloading above nominal, at or under maximum overload.
// - Stalled when current exceeds maximum overload.
// - Stalled also when current exceeds maximum locked-rotor limit.
// - Missing phase only while starting or running, one phase under no-load.
// - All status outputs offered; changes pulse an event strobe.
// - Setting updates from protection functions overwrite the shared copy.
// - Direct or star-delta start needs both limits crossed within 10 ms.
// - Force setting overrides computed status; no_override does nothing.
`timescale 1ns/10ps
`default_nettype none
module mstm_top
    import mstm_pkg::*;
#(
    parameter int NOLOAD_CYCLES = NOLOAD_CYC, // No-load qualification time
    parameter int RISE_CYCLES   = RISE_CYC,   // Start rise window
    parameter int TICK_CYCLES   = TICK_CYC    // Timer tick, 1 ms
) (
    input  wire logic             clk,            // 200 MHz clock
    input  wire logic             rst_n,          // Synchronous reset, active low
    input  wire logic             psel,           // APB select
    input  wire logic             penable,        // APB enable
    input  wire logic             pwrite,         // APB direction
    input  wire logic [31:0]      paddr,          // APB address
    input  wire logic [31:0]      pwdata,         // APB write data
    output logic      [31:0]      prdata,         // APB read data
    output logic                  pready,         // APB ready
    output logic                  pslverr,        // APB error
    input  wire logic             sampleValid,    // One program cycle sample
    input  wire logic [CUR_W-1:0] curL1,          // Phase 1 magnitude
    input  wire logic [CUR_W-1:0] curL2,          // Phase 2 magnitude
    input  wire logic [CUR_W-1:0] curL3,          // Phase 3 magnitude
    input  wire logic             extSetValid,    // Setting update from a protection function
    input  wire logic [2:0]       extSetSel,      // Which limit is updated
    input  wire logic [CUR_W-1:0] extSetValue,    // New limit value
    output logic                  motorStopped,   // Stopped status
    output logic                  motorStarting,  // Starting status
    output logic                  motorRunning,   // Running status
    output logic                  loadNormal,     // Normal load
    output logic                  overloading,    // Overloading
    output logic                  motorStalled,   // Stalled
    output logic                  missingPhase,   // Missing phase
    output logic                  highOverload,   // Above locked-rotor limit
    output logic                  statusEvent     // Pulse on any status change
);
    // Settings
    logic [CUR_W-1:0]  noLoad_ff, startDet_ff, nominal_ff, maxOvl_ff, maxLr_ff;
    logic [15:0]       svcFactor_ff, ambFactor_ff;
    logic [3:0]        motor_status_force_ff;
    logic              forceEn_ff;
    logic [1:0]        startMode_ff;
    // Computed state and statistics
    mstm_state_e       state_ff;
    logic [CNT_W-1:0]  starts_ff, goodStarts_ff, stops_ff;
    logic [CNT_W-1:0]  runTime_ff, startTime_ff, stopTime_ff, lastStop_ff, clock_ff;
    logic [31:0]       lowCnt_ff, riseCnt_ff, tickCnt_ff;
    logic              riseArmed_ff;
    logic [8:0]        status_ff;
    logic [CUR_W-1:0]  curMax, curMin, nomAdj;
    logic [47:0]       nomProd;
    logic              wrEn, tick, lowNow, startOk, quietLong, startNow;
    logic [8:0]        calc, shown;

    assign wrEn    = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Highest and lowest phase magnitude
    always_comb begin
        curMax = (curL1 > curL2) ? curL1 : curL2;
        curMax = (curL3 > curMax) ? curL3 : curMax;
        curMin = (curL1 < curL2) ? curL1 : curL2;
        curMin = (curL3 < curMin) ? curL3 : curMin;
    end

    // Nominal scaled by both 8.8 factors; saturates rather than wraps
    assign nomProd = (48'(nominal_ff) * 48'(svcFactor_ff) * 48'(ambFactor_ff)) >> 16;
    assign nomAdj  = (nomProd[47:16] != 32'h0) ? 16'hFFFF : nomProd[15:0];

    // Settings, APB side and shared-copy updates from protection functions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            noLoad_ff <= NOLOAD_RST;
            startDet_ff <= STARTDET_RST;
            nominal_ff <= NOMINAL_RST;
            maxOvl_ff <= MAXOVL_RST;
            maxLr_ff <= MAXLR_RST;
            svcFactor_ff <= FACTOR_ONE;
            ambFactor_ff <= FACTOR_ONE;
            motor_status_force_ff <= FORCE_RST;
            forceEn_ff <= 1'b0;
            startMode_ff <= STARTMODE_RST;
        end else if (extSetValid) begin
            // Function-side edits win a same-cycle APB write
            unique case (extSetSel)
                3'h0: noLoad_ff <= extSetValue;
                3'h1: startDet_ff <= extSetValue;
                3'h2: nominal_ff <= extSetValue;
                3'h3: maxOvl_ff <= extSetValue;
                3'h4: maxLr_ff <= extSetValue;
                default: ;
            endcase
        end else if (wrEn) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    motor_status_force_ff <= pwdata[3:0];
                    forceEn_ff <= pwdata[4];
                    startMode_ff <= pwdata[9:8];
                end
                ADDR_NOLOAD:   noLoad_ff <= pwdata[15:0];
                ADDR_STARTDET: startDet_ff <= pwdata[15:0];
                ADDR_NOMINAL:  nominal_ff <= pwdata[15:0];
                ADDR_MAXOVL:   maxOvl_ff <= pwdata[15:0];
                ADDR_MAXLR:    maxLr_ff <= pwdata[15:0];
                ADDR_FACTORS: begin
                    svcFactor_ff <= pwdata[15:0];
                    ambFactor_ff <= pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // Millisecond tick for the timers and the timestamp clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickCnt_ff <= 32'h0;
        end else if (tickCnt_ff == 32'(TICK_CYCLES - 1)) begin
            tickCnt_ff <= 32'h0;
        end else begin
            tickCnt_ff <= tickCnt_ff + 32'h1;
        end
    end
    assign tick   = (tickCnt_ff == 32'(TICK_CYCLES - 1));
    assign lowNow = (curMax < noLoad_ff);
    assign quietLong = lowNow && (lowCnt_ff > 32'(NOLOAD_CYCLES));

    // No-load qualification counts clock cycles, not samples
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowCnt_ff <= 32'h0;
        end else if (sampleValid && !lowNow) begin
            lowCnt_ff <= 32'h0;
        end else if (lowCnt_ff != 32'hFFFFFFFF) begin
            lowCnt_ff <= lowCnt_ff + 32'h1;
        end
    end

    // Rise window opens when current leaves no-load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            riseArmed_ff <= 1'b0;
            riseCnt_ff <= 32'h0;
        end else if (state_ff != ST_STOPPED || (sampleValid && lowNow)) begin
            riseArmed_ff <= 1'b0;
            riseCnt_ff <= 32'h0;
        end else if (sampleValid && !riseArmed_ff) begin
            riseArmed_ff <= 1'b1;
            riseCnt_ff <= 32'h0;
        end else if (riseArmed_ff && riseCnt_ff != 32'hFFFFFFFF) begin
            riseCnt_ff <= riseCnt_ff + 32'h1;
        end
    end
    // Soft start has no rise limit; a slow rise in the other modes is never a start
    assign startOk = (startMode_ff == MODE_SOFT) ||
                     (riseArmed_ff ? (riseCnt_ff <= 32'(RISE_CYCLES)) : 1'b1);
    assign startNow = (curMax > startDet_ff) && (curMax > noLoad_ff) && startOk;

    // Stopped / starting / running; one state held at a time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_STOPPED;
        end else if (sampleValid) begin
            unique case (state_ff)
                ST_STOPPED: begin
                    if (startNow) begin
                        state_ff <= ST_STARTING;
                    end
                end
                ST_STARTING: begin
                    if (quietLong) begin
                        state_ff <= ST_STOPPED;
                    end else if (curMax < maxOvl_ff) begin
                        state_ff <= ST_RUNNING;
                    end else begin
                        state_ff <= ST_STARTING;
                    end
                end
                ST_RUNNING: begin
                    if (quietLong) begin
                        state_ff <= ST_STOPPED;
                    end
                end
                default: state_ff <= ST_STOPPED;
            endcase
        end
    end

    // Counters of starts, successful starts and stops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            starts_ff <= 32'h0;
            goodStarts_ff <= 32'h0;
            stops_ff <= 32'h0;
        end else if (sampleValid) begin
            if (state_ff == ST_STOPPED && startNow) begin
                starts_ff <= starts_ff + 32'h1;
            end
            if (state_ff == ST_STARTING && !quietLong && curMax < maxOvl_ff) begin
                goodStarts_ff <= goodStarts_ff + 32'h1;
            end
            if (state_ff != ST_STOPPED && quietLong) begin
                stops_ff <= stops_ff + 32'h1;
            end
        end
    end

    // Millisecond timers and last-stop timestamp
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runTime_ff <= 32'h0;
            startTime_ff <= 32'h0;
            stopTime_ff <= 32'h0;
            clock_ff <= 32'h0;
            lastStop_ff <= 32'h0;
        end else begin
            if (tick) begin
                clock_ff <= clock_ff + 32'h1;
                unique case (state_ff)
                    ST_RUNNING:  runTime_ff <= runTime_ff + 32'h1;
                    ST_STARTING: startTime_ff <= startTime_ff + 32'h1;
                    default:     stopTime_ff <= stopTime_ff + 32'h1;
                endcase
            end
            if (sampleValid && state_ff != ST_STOPPED && quietLong) begin
                lastStop_ff <= clock_ff;
            end
        end
    end

    // Computed load status, bit order stop,start,run,stall,asym,norm,ovl,hiovl,spare
    always_comb begin
        calc = 9'h000;
        calc[0] = (state_ff == ST_STOPPED);
        calc[1] = (state_ff == ST_STARTING);
        calc[2] = (state_ff == ST_RUNNING);
        calc[3] = (curMax > maxOvl_ff) || (curMax > maxLr_ff);
        calc[4] = (state_ff != ST_STOPPED) && (curMin < noLoad_ff) && !lowNow;
        calc[5] = (curMax >= noLoad_ff) && (curMax <= nomAdj);
        calc[6] = (curMax > nomAdj) && (curMax <= maxOvl_ff);
        calc[7] = (curMax > maxLr_ff);
    end

    // Forcing replaces the whole status with one chosen state
    always_comb begin
        shown = calc;
        if (forceEn_ff && motor_status_force_ff != FORCE_NONE) begin
            shown = 9'h000;
            unique case (motor_status_force_ff)
                FORCE_STOP:  shown[0] = 1'b1;
                FORCE_START: shown[1] = 1'b1;
                FORCE_RUN:   shown[2] = 1'b1;
                FORCE_STALL: begin shown[2] = 1'b1; shown[3] = 1'b1; end
                FORCE_ASYM:  begin shown[2] = 1'b1; shown[4] = 1'b1; end
                FORCE_NORM:  begin shown[2] = 1'b1; shown[5] = 1'b1; end
                FORCE_OVL:   begin shown[2] = 1'b1; shown[6] = 1'b1; end
                FORCE_HIOVL: begin shown[2] = 1'b1; shown[3] = 1'b1; shown[7] = 1'b1; end
                default:     shown = calc;
            endcase
        end
    end

    // Registered status outputs and change strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_ff <= 9'h001;
            statusEvent <= 1'b0;
        end else begin
            status_ff <= shown;
            statusEvent <= (shown != status_ff);
        end
    end
    assign motorStopped  = status_ff[0];
    assign motorStarting = status_ff[1];
    assign motorRunning  = status_ff[2];
    assign motorStalled  = status_ff[3];
    assign missingPhase  = status_ff[4];
    assign loadNormal    = status_ff[5];
    assign overloading   = status_ff[6];
    assign highOverload  = status_ff[7];

    // Read mux; zero-wait, unmapped reads zero
    always_comb begin
        unique case (paddr)
            ADDR_CTRL:      prdata = {22'h0, startMode_ff, 3'h0, forceEn_ff,
                                      motor_status_force_ff};
            ADDR_STATUS:    prdata = {23'h0, status_ff};
            ADDR_NOLOAD:    prdata = {16'h0, noLoad_ff};
            ADDR_STARTDET:  prdata = {16'h0, startDet_ff};
            ADDR_NOMINAL:   prdata = {16'h0, nominal_ff};
            ADDR_MAXOVL:    prdata = {16'h0, maxOvl_ff};
            ADDR_MAXLR:     prdata = {16'h0, maxLr_ff};
            ADDR_FACTORS:   prdata = {ambFactor_ff, svcFactor_ff};
            ADDR_STARTS:    prdata = starts_ff;
            ADDR_GOODSTART: prdata = goodStarts_ff;
            ADDR_STOPS:     prdata = stops_ff;
            ADDR_RUNTIME:   prdata = runTime_ff;
            ADDR_STARTTIME: prdata = startTime_ff;
            ADDR_STOPTIME:  prdata = stopTime_ff;
            ADDR_LASTSTOP:  prdata = lastStop_ff;
            ADDR_CLOCK:     prdata = clock_ff;
            default:        prdata = 32'h0;
        endcase
    end
endmodule
`default_nettype wire

// ---- mstm_monitor.sv ----
// Port checker for the motor status monitor.
// Assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module mstm_monitor (
    input wire logic clk,           // Clock
    input wire logic rst_n,         // Reset, active low
    input wire logic motorStopped,  // Stopped status
    input wire logic motorStarting, // Starting status
    input wire logic motorRunning,  // Running status
    input wire logic loadNormal,    // Normal load
    input wire logic overloading,   // Overloading
    input wire logic motorStalled,  // Stalled
    input wire logic missingPhase,  // Missing phase
    input wire logic highOverload,  // Above locked-rotor limit
    input wire logic statusEvent    // Change strobe
);
    logic [7:0] stVec;

    // Same bit order as the status register
    assign stVec = {highOverload, overloading, loadNormal, missingPhase,
                    motorStalled, motorRunning, motorStarting, motorStopped};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Steps of a status change and of a start
    sequence s_change;
        stVec != $past(stVec);
    endsequence
    sequence s_enter_start;
        $rose(motorStarting);
    endsequence

    chk_one_state: assert property ($onehot({motorStopped, motorStarting, motorRunning}))
        else $error("state not one-hot");
    chk_missing_active: assert property (missingPhase |-> !motorStopped)
        else $error("missing while stopped");
    chk_stall_ovl_excl: assert property (!(motorStalled && overloading))
        else $error("stall with overload");
    chk_high_stall: assert property (highOverload |-> motorStalled)
        else $error("high without stall");
    chk_event_follow: assert property (s_change |-> statusEvent)
        else $error("change without strobe");
    chk_event_cause: assert property (statusEvent |-> s_change)
        else $error("strobe without change");
    chk_start_order: assert property (s_enter_start |-> $past(motorStopped))
        else $error("start not from stopped");
    chk_run_order: assert property ($rose(motorRunning) |-> $past(motorStarting))
        else $error("run without start");
endmodule

bind mstm_top mstm_monitor mstm_monitor_inst (.clk, .rst_n, .motorStopped, .motorStarting,
    .motorRunning, .loadNormal, .overloading, .motorStalled, .missingPhase, .highOverload,
    .statusEvent);
`default_nettype wire

// ---- mstm_prot_model.sv ----
// Consumer of the motor status outputs, as protection logic would use them.
// Assumes the change strobe rises together with the new status.
`timescale 1ns/10ps
`default_nettype none
module mstm_prot_model (
    input  wire logic       clk,         // Clock
    input  wire logic       rst_n,       // Reset, active low
    input  wire logic [7:0] statusIn,    // Monitor status outputs
    input  wire logic       statusEvent, // Change strobe
    output logic      [7:0] lastStatus,  // Status taken on the strobe
    output logic            lowSetBlock  // Blocks a low-set stage while starting
);
    // Only the strobe refreshes the copy, so a lost strobe leaves it stale
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastStatus <= 8'h01;
        end else if (statusEvent) begin
            lastStatus <= statusIn;
        end
    end

    // Application use of the starting status
    assign lowSetBlock = lastStatus[1];
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the motor status monitor.
// Assumes shortened qualification, rise and tick counts of 20, 20 and 10.
`timescale 1ns/10ps
`default_nettype none
module tb
    import mstm_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, last;
    logic        sampleValid = 1'b0, extSetValid = 1'b0;
    logic [2:0]  extSetSel = 3'h0;
    logic [15:0] curL1 = 16'h0, curL2 = 16'h0, curL3 = 16'h0, extSetValue = 16'h0;
    logic [15:0] nomV = NOMINAL_RST, svcV = FACTOR_ONE, r1, r2, r3;
    logic [31:0] prdata;
    logic        pready, pslverr, statusEvent, lowSetBlock;
    logic        motorStopped, motorStarting, motorRunning, loadNormal, overloading;
    logic        motorStalled, missingPhase, highOverload;
    logic [7:0]  statusVec, lastStatus, e;
    int          mismatches = 0, samples_checked = 0, seed = 32'hE818, i;
    logic [31:0] ra [9] = '{ADDR_CTRL, ADDR_STATUS, ADDR_NOLOAD, ADDR_STARTDET, ADDR_NOMINAL,
                            ADDR_MAXOVL, ADDR_MAXLR, ADDR_STARTS, ADDR_STOPS};
    logic [31:0] rv [9] = '{{22'h0, STARTMODE_RST, 4'h0, FORCE_RST}, 32'h1, 32'(NOLOAD_RST),
                            32'(STARTDET_RST), 32'(NOMINAL_RST), 32'(MAXOVL_RST),
                            32'(MAXLR_RST), 32'h0, 32'h0};
    logic [7:0]  fexp [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h0C, 8'h14, 8'h24, 8'h44,
                               8'h8C, 8'h01};

    assign statusVec = {highOverload, overloading, loadNormal, missingPhase,
                        motorStalled, motorRunning, motorStarting, motorStopped};

    mstm_top #(.NOLOAD_CYCLES(20), .RISE_CYCLES(20), .TICK_CYCLES(10)) mstm_top_inst (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sampleValid, .curL1, .curL2, .curL3, .extSetValid, .extSetSel, .extSetValue,
        .motorStopped, .motorStarting, .motorRunning, .loadNormal, .overloading,
        .motorStalled, .missingPhase, .highOverload, .statusEvent);
    mstm_prot_model mstm_prot_model_inst (.clk, .rst_n, .statusIn(statusVec), .statusEvent,
        .lastStatus, .lowSetBlock);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [31:0] adr, input logic [31:0] exp, input string name);
        apb(1'b0, adr, 32'h0);
        chk(name, rd, exp);
    endtask

    // Expected status, ambient factor left at one
    function automatic logic [7:0] expst(input int s, input logic [15:0] a, b, c);
        logic [15:0] mx;
        logic [15:0] mn;
        logic [31:0] adj;
        mx = (a > b) ? a : b;
        mx = (c > mx) ? c : mx;
        mn = (a < b) ? a : b;
        mn = (c < mn) ? c : mn;
        adj = (32'(nomV) * 32'(svcV)) >> 8;
        return {mx > MAXLR_RST, mx > nomV && mx <= MAXOVL_RST,
                mx >= NOLOAD_RST && 32'(mx) <= adj,
                s != 0 && mn < NOLOAD_RST && mx >= NOLOAD_RST,
                mx > MAXOVL_RST || mx > MAXLR_RST, s == 2, s == 1, s == 0};
    endfunction

    // One program-cycle sample, then wait for status and strobe to land
    task automatic smp(input logic [15:0] a, b, c);
        @(posedge clk);
        curL1 <= a;
        curL2 <= b;
        curL3 <= c;
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic smpc(input logic [15:0] a, b, c, input int s);
        smp(a, b, c);
        chk("status", 32'(statusVec), 32'(expst(s, a, b, c)));
        chk("consumer", 32'(lastStatus), 32'(statusVec));
        chk("lowset", 32'(lowSetBlock), 32'(s == 1));
    endtask

    // Low current: state held over 4 samples, stopped by the 8th
    task automatic stopseq(input int s);
        repeat (4) smp(16'h0, 16'h0, 16'h0);
        chk("early", 32'(statusVec), 32'(expst(s, 16'h0, 16'h0, 16'h0)));
        repeat (4) smp(16'h0, 16'h0, 16'h0);
        chk("stop", 32'(statusVec), 32'(expst(0, 16'h0, 16'h0, 16'h0)));
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 9; i++) rdc(ra[i], rv[i], "reset");
        apb(1'b1, ADDR_STATUS, 32'hFF);
        apb(1'b1, 32'h0000_0040, 32'h1);
        rdc(ADDR_STATUS, 32'h1, "ro");
        // Direct start through all load levels, then a stop
        repeat (3) smpc(16'h0300, 16'h0300, 16'h0300, 1);
        smpc(16'h0180, 16'h0180, 16'h0180, 2);
        smpc(16'h0080, 16'h0080, 16'h0010, 2);
        smpc(16'h0900, 16'h0900, 16'h0900, 2);
        stopseq(2);
        rdc(ADDR_STARTS, 32'h1, "starts");
        rdc(ADDR_GOODSTART, 32'h1, "good");
        rdc(ADDR_STOPS, 32'h1, "stops");
        for (i = 0; i < 3; i++) begin
            apb(1'b0, ADDR_RUNTIME + 32'(4 * i), 32'h0);
            chk("timer", 32'(rd != 0), 32'h1);
        end
        apb(1'b0, ADDR_LASTSTOP, 32'h0);
        last = rd;
        apb(1'b0, ADDR_CLOCK, 32'h0);
        chk("laststop", 32'(last != 0 && last <= rd), 32'h1);
        // Slow rise in direct mode is not a start
        repeat (6) smpc(16'h0040, 16'h0040, 16'h0040, 0);
        smpc(16'h0300, 16'h0300, 16'h0300, 0);
        stopseq(0);
        for (i = 1; i < 3; i++) begin
            apb(1'b1, ADDR_CTRL, {22'h0, (i == 1) ? MODE_STARDELTA : MODE_SOFT, 8'h00});
            if (i == 2) repeat (6) smp(16'h0040, 16'h0040, 16'h0040);
            smpc(16'h0300, 16'h0300, 16'h0300, 1);
            smpc(16'h0180, 16'h0180, 16'h0180, 2);
            stopseq(2);
        end
        rdc(ADDR_STARTS, 32'h3, "starts");
        rdc(ADDR_GOODSTART, 32'h3, "good");
        rdc(ADDR_STOPS, 32'h3, "stops");
        // Setting pushed from a protection function; select 7 is ignored
        @(posedge clk);
        extSetValid <= 1'b1;
        extSetSel <= 3'h2;
        extSetValue <= 16'h0140;
        @(posedge clk);
        extSetSel <= 3'h7;
        extSetValue <= 16'h0001;
        @(posedge clk);
        extSetValid <= 1'b0;
        nomV = 16'h0140;
        rdc(ADDR_NOMINAL, 32'h0000_0140, "shared");
        // Service factor 1.5 widens the normal band
        smpc(16'h0300, 16'h0300, 16'h0300, 1);
        apb(1'b1, ADDR_FACTORS, {FACTOR_ONE, 16'h0180});
        svcV = 16'h0180;
        smp(16'h01C0, 16'h01C0, 16'h01C0);
        e = expst(2, 16'h01C0, 16'h01C0, 16'h01C0);
        chk("factor", 32'(statusVec[5]), 32'(e[5]));
        apb(1'b1, ADDR_FACTORS, {FACTOR_ONE, FACTOR_ONE});
        svcV = FACTOR_ONE;
        repeat (40) begin
            r1 = 16'h0020 + 16'($random(seed) & 32'h7FF);
            r2 = 16'($random(seed) & 32'h7FF);
            r3 = 16'($random(seed) & 32'h7FF);
            smpc(r1, r2, r3, 2);
        end
        stopseq(2);
        // Force codes 1 to 8, then undefined code 9, which shows the computed status
        for (i = 1; i < 10; i++) begin
            apb(1'b1, ADDR_CTRL, {27'h0, 1'b1, 4'(i)});
            smp(16'h0, 16'h0, 16'h0);
            chk("forced", 32'(statusVec), 32'(fexp[i]));
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
